// File: rdr_regs.svh
// Register offsets, field positions, reset values and sizes of the refresh path
`ifndef RDR_REGS_SVH
`define RDR_REGS_SVH
`define RDR_OFF_ROT_MODE 12'h000
`define RDR_OFF_STRIDE 12'h004
`define RDR_OFF_START 12'h008
`define RDR_OFF_CTRL 12'h00C
`define RDR_OFF_GEOM 12'h010
`define RDR_OFF_STATUS 12'h014
`define RDR_OFF_LUT_BASE 12'h400
`define RDR_OFF_FB_BASE 12'h800
`define RDR_BIT_ROT_EN 7
`define RDR_BIT_ROT_ALT 6
`define RDR_BIT_INVERT 0
`define RDR_BIT_RUN 1
`define RDR_FB_BYTES 32'd81920
`define RDR_ADDR_W 17
`define RDR_RST_GEOM 32'h0000_0000
`endif

// File: rdr_pkg.sv
// Types shared by the rotated display refresh path
package rdr_pkg;
  typedef enum logic [3:0] {
    RDR_IDLE = 4'b0001,
    RDR_FETCH = 4'b0010,
    RDR_SHIFT = 4'b0100,
    RDR_WAIT = 4'b1000
  } rdr_state_t;
  typedef struct packed {
    logic rot_en;
    logic rot_alt;
    logic [1:0] clk_sel;
  } rdr_mode_t;
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rdr_pix_t;
endpackage

// File: rdr_refresh.sv
// Rotated display refresh path with colour lookup and APB register file
//
// Contract
// [RL1] Invert pixel data after the lookup table
// [RL2] Monochrome depths use green table only
// [RL3] Colour depths index red, green, blue tables
// [RL4] Refresh only from the 80K byte buffer
// [RL5] Two rotated variants, default and alternate
// [RL6] Fetch corners in order B, D, A, C
// [RL7] Software picks variant with bits 7,6
// [RL8] Default variant width is power of two
// [RL9] Memory clock at least pixel clock, default
// [RL10] Memory clock twice pixel clock, alternate
// [RL11] Input clock at most 25 MHz; the bench clock runs at 50 MHz
// [RL12] Refresh starts at corner B start address
// [RL13] Step lines by stride, 00h means 256
// [RL14] Alternate stride is actual image width
// [RL15] Start plus one pans one byte
// [RL16] Default vertical pan in two-line steps
// [RL17] Alternate stride added pans one line
// [RL18] No split screen in rotated mode
// [RL19] Enable bit 0 means landscape refresh
// [RL20] Clock select field picks clock divisors; code uses it in rotated mode only, landscape runs both strobes at full rate
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "rdr_regs.svh"
module rdr_refresh #(
  parameter int FB_BYTES = `RDR_FB_BYTES,
  parameter int MAX_LINES = 1024
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`RDR_ADDR_W-1:0] fb_waddr,
  input wire logic [7:0] fb_wdata,
  input wire logic fb_we,
  output rdr_pkg::rdr_pix_t pix_q,
  output logic pclk_en_q,
  output logic mclk_en_q
);
  localparam int AW = `RDR_ADDR_W;

  // Elaboration checks refuse sizes the address and line counters cannot reach
  if (FB_BYTES > (1 << AW) || FB_BYTES < 256) begin : g_bad_fb
    $error("FB_BYTES out of range");
  end
  if (MAX_LINES < 1 || MAX_LINES > 1024) begin : g_bad_lines
    $error("MAX_LINES out of range");
  end

  // ==========================================================
  // Storage
  // ==========================================================
  logic [7:0] fb_mem [0:FB_BYTES-1];
  logic [7:0] lut_r [0:15];
  logic [7:0] lut_g [0:15];
  logic [7:0] lut_b [0:15];
  logic [7:0] lut8_r [0:255];
  logic [7:0] lut8_g [0:255];
  logic [7:0] lut8_b [0:255];

  // ==========================================================
  // Registers
  // ==========================================================
  rdr_pkg::rdr_mode_t mode_q;
  logic [7:0] stride_q;
  logic [AW-1:0] start_q;
  logic invert_q;
  logic run_q;
  logic mono_q;
  logic [1:0] bpp_q;
  logic [9:0] lines_q;
  logic [7:0] bytes_q;
  rdr_pkg::rdr_state_t state_q;
  logic [AW-1:0] line_base_q;
  logic [AW-1:0] addr_q;
  logic [9:0] line_cnt_q;
  logic [7:0] byte_cnt_q;
  logic [7:0] byte_q;
  logic [3:0] pix_left_q;
  logic [2:0] div_q;
  logic pix_tick;
  logic mem_tick;
  logic bus_wr;
  logic bus_rd;
  logic [8:0] stride_eff;
  logic [3:0] pix_per_byte;
  logic [7:0] idx;
  logic [7:0] lr;
  logic [7:0] lg;
  logic [7:0] lb;

  assign bus_wr = psel && penable && pwrite;
  assign bus_rd = psel && !penable && !pwrite;

  // Stride of 00h stands for 256 bytes
  assign stride_eff = (stride_q == 8'h00) ? 9'h100 : {1'b0, stride_q}; // RL13

  // Control register writes; rotated fields stored in landscape too
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= '0;
      stride_q <= 8'h00;
      start_q <= '0;
      invert_q <= 1'b0;
      run_q <= 1'b0;
      mono_q <= 1'b0;
      bpp_q <= 2'h0;
      lines_q <= 10'h000;
      bytes_q <= 8'h00;
    end else if (bus_wr) begin
      case (paddr)
        `RDR_OFF_ROT_MODE: begin
          mode_q.rot_en <= pwdata[`RDR_BIT_ROT_EN]; // RL19
          mode_q.rot_alt <= pwdata[`RDR_BIT_ROT_ALT]; // RL5
          mode_q.clk_sel <= pwdata[1:0];
        end
        `RDR_OFF_STRIDE: stride_q <= pwdata[7:0];
        `RDR_OFF_START: start_q <= pwdata[AW-1:0]; // RL12
        `RDR_OFF_CTRL: begin
          invert_q <= pwdata[`RDR_BIT_INVERT];
          run_q <= pwdata[`RDR_BIT_RUN];
          mono_q <= pwdata[2];
          bpp_q <= pwdata[5:4];
        end
        `RDR_OFF_GEOM: begin
          lines_q <= pwdata[9:0];
          bytes_q <= pwdata[23:16];
        end
        default: begin
        end
      endcase
    end
  end

  // Lookup table writes, index in word address, colours in low bytes
  always_ff @(posedge clock) begin
    if (bus_wr && paddr[11:10] == 2'b01) begin
      lut8_r[paddr[9:2]] <= pwdata[23:16];
      lut8_g[paddr[9:2]] <= pwdata[15:8];
      lut8_b[paddr[9:2]] <= pwdata[7:0];
      if (paddr[9:6] == 4'h0) begin
        lut_r[paddr[5:2]] <= pwdata[23:16];
        lut_g[paddr[5:2]] <= pwdata[15:8];
        lut_b[paddr[5:2]] <= pwdata[7:0];
      end
    end
  end

  // Frame buffer fill from host side; out-of-range bytes dropped
  always_ff @(posedge clock) begin
    if (fb_we && fb_waddr < AW'(FB_BYTES)) begin // RL4
      fb_mem[fb_waddr] <= fb_wdata;
    end
  end

  // APB read data and answer: no wait state, unmapped reads give error
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (bus_rd) begin
        case (paddr)
          `RDR_OFF_ROT_MODE: prdata <= {24'h0, mode_q.rot_en, mode_q.rot_alt, 4'h0,
                                        mode_q.clk_sel};
          `RDR_OFF_STRIDE: prdata <= {24'h0, stride_q};
          `RDR_OFF_START: prdata <= {{(32-AW){1'b0}}, start_q};
          `RDR_OFF_CTRL: prdata <= {26'h0, bpp_q, 1'b0, mono_q, run_q, invert_q};
          `RDR_OFF_GEOM: prdata <= {8'h0, bytes_q, 6'h0, lines_q};
          `RDR_OFF_STATUS: prdata <= {{(32-AW){1'b0}}, addr_q} | {28'h0, state_q} << 28;
          default: begin
            prdata <= 32'h0000_0000;
            pslverr <= (paddr[11:10] != 2'b01);
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Clock divisors
  // ==========================================================
  // Free divider; select picks memory and pixel tick rates in rotated mode, landscape ticks both every cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // Alternate variant runs memory at twice the pixel rate
  always_comb begin
    pix_tick = 1'b1;
    mem_tick = 1'b1;
    if (mode_q.rot_en) begin // RL19
      case (mode_q.clk_sel) // RL20
        2'b00: begin
          pix_tick = mode_q.rot_alt ? div_q[0] : 1'b1;
          mem_tick = 1'b1;
        end
        2'b01: begin
          pix_tick = div_q[0];
          mem_tick = mode_q.rot_alt ? 1'b1 : div_q[0];
        end
        2'b10: begin
          pix_tick = div_q[1:0] == 2'b11;
          mem_tick = mode_q.rot_alt ? div_q[0] : (div_q[1:0] == 2'b11);
        end
        default: begin
          pix_tick = div_q == 3'b111;
          mem_tick = mode_q.rot_alt ? (div_q[1:0] == 2'b11) : (div_q == 3'b111);
        end
      endcase
    end
  end

  // Clock enable strobes brought out from flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pclk_en_q <= 1'b0;
      mclk_en_q <= 1'b0;
    end else begin
      pclk_en_q <= pix_tick;
      mclk_en_q <= mem_tick;
    end
  end

  // ==========================================================
  // Refresh fetch sequencer
  // ==========================================================
  always_comb begin
    case (bpp_q)
      2'b00: pix_per_byte = 4'd8;
      2'b01: pix_per_byte = 4'd4;
      2'b10: pix_per_byte = 4'd2;
      default: pix_per_byte = 4'd1;
    endcase
  end

  // Landscape walks bytes forward; rotated walks down column from B by stride
  // then steps one byte back per line, giving B-D then A-C order
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rdr_pkg::RDR_IDLE;
      line_base_q <= '0;
      addr_q <= '0;
      line_cnt_q <= 10'h000;
      byte_cnt_q <= 8'h00;
      byte_q <= 8'h00;
      pix_left_q <= 4'h0;
    end else begin
      case (state_q)
        rdr_pkg::RDR_IDLE: begin
          if (run_q) begin
            line_base_q <= start_q; // RL12 RL15 RL16 RL17 RL18
            addr_q <= start_q;
            line_cnt_q <= 10'h000;
            byte_cnt_q <= 8'h00;
            state_q <= rdr_pkg::RDR_FETCH;
          end
        end
        rdr_pkg::RDR_FETCH: begin
          if (mem_tick) begin
            byte_q <= (addr_q < AW'(FB_BYTES)) ? fb_mem[addr_q] : 8'h00; // RL4
            pix_left_q <= pix_per_byte;
            state_q <= rdr_pkg::RDR_SHIFT;
          end
        end
        rdr_pkg::RDR_SHIFT: begin
          if (pix_tick) begin
            byte_q <= byte_q << (4'd8 / pix_per_byte);
            pix_left_q <= pix_left_q - 4'h1;
            if (pix_left_q == 4'h1) begin
              state_q <= rdr_pkg::RDR_WAIT;
            end
          end
        end
        default: begin
          if (byte_cnt_q == bytes_q) begin
            byte_cnt_q <= 8'h00;
            if (line_cnt_q == lines_q || !run_q) begin
              state_q <= rdr_pkg::RDR_IDLE; // RL18
            end else begin
              line_cnt_q <= line_cnt_q + 10'h001;
              if (mode_q.rot_en) begin
                line_base_q <= line_base_q - AW'(1); // RL6
                addr_q <= line_base_q - AW'(1);
              end else begin
                addr_q <= addr_q + AW'(1);
              end
              state_q <= rdr_pkg::RDR_FETCH;
            end
          end else begin
            byte_cnt_q <= byte_cnt_q + 8'h01;
            if (mode_q.rot_en) begin
              // Power-of-two stride in default, true width in alternate
              addr_q <= addr_q + AW'(stride_eff); // RL6 RL8 RL13 RL14
            end else begin
              addr_q <= addr_q + AW'(1); // RL19
            end
            state_q <= rdr_pkg::RDR_FETCH;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Colour lookup output path
  // ==========================================================
  always_comb begin
    case (bpp_q)
      2'b00: idx = {7'h0, byte_q[7]};
      2'b01: idx = {6'h0, byte_q[7:6]};
      2'b10: idx = {4'h0, byte_q[7:4]};
      default: idx = byte_q;
    endcase
    if (bpp_q == 2'b11) begin
      lr = lut8_r[idx];
      lg = lut8_g[idx];
      lb = lut8_b[idx];
    end else begin
      lr = lut_r[idx[3:0]];
      lg = lut_g[idx[3:0]];
      lb = lut_b[idx[3:0]];
    end
  end

  // Pixel output; inversion applied after table lookup
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pix_q <= '0;
    end else begin
      pix_q.valid <= (state_q == rdr_pkg::RDR_SHIFT) && pix_tick;
      pix_q.first <= (state_q == rdr_pkg::RDR_SHIFT) && pix_tick && line_cnt_q == 10'h000
                     && byte_cnt_q == 8'h00 && pix_left_q == pix_per_byte;
      if (mono_q) begin
        pix_q.red <= lg ^ {8{invert_q}}; // RL1 RL2
        pix_q.green <= lg ^ {8{invert_q}}; // RL2
        pix_q.blue <= lg ^ {8{invert_q}}; // RL2
      end else begin
        pix_q.red <= lr ^ {8{invert_q}}; // RL1 RL3
        pix_q.green <= lg ^ {8{invert_q}}; // RL3
        pix_q.blue <= lb ^ {8{invert_q}}; // RL3
      end
    end
  end
endmodule

// File: rdr_panel_model.sv
// Panel model that collects the pixels of each frame
`timescale 1ns/1ns
module rdr_panel_model (
  input wire logic clock,
  input wire rdr_pkg::rdr_pix_t pix_q
);
  logic [23:0] got [$];
  // ==========
  // Capture pixels from the frame start marker onward
  always @(posedge clock) begin
    if (pix_q.valid && (pix_q.first || got.size() > 0)) begin
      got.push_back({pix_q.red, pix_q.green, pix_q.blue});
    end
  end
endmodule

// File: rdr_refresh_properties.sv
// Checker of bus answers and clock strobes of the refresh path
`timescale 1ns/1ns
module rdr_refresh_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rdr_pkg::rdr_pix_t pix_q,
  input wire logic pclk_en_q,
  input wire logic mclk_en_q
);
  logic [7:0] mode_q;
  logic [2:0] age_q;
  logic ok_q;
  assign ok_q = age_q > 3'h3;
  // ==========
  // Mode register copy and cycles since its last write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 8'h00;
      age_q <= 3'h0;
    end else if (psel && penable && pwrite && pready && paddr == 12'h000) begin
      mode_q <= pwdata[7:0];
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  a_ready_access: assert property (s_setup |=> s_answer)
    else $error("no answer in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_on_read: assert property (pslverr |-> pready && !pwrite)
    else $error("error outside a read answer");
  a_lut_reads_zero: assert property (psel && penable && pready && !pwrite
    && paddr[11:10] == 2'b01 |-> prdata == 32'h0 && !pslverr)
    else $error("table read not zero");
  a_land_ticks: assert property (!mode_q[7] && ok_q |-> pclk_en_q && mclk_en_q)
    else $error("landscape strobes not every cycle");
  a_def_full_rate: assert property (mode_q[7:6] == 2'b10 && mode_q[1:0] == 2'b00 && ok_q
    |-> pclk_en_q && mclk_en_q) else $error("default strobes wrong");
  a_alt_pix_half: assert property (mode_q[7:6] == 2'b11 && ok_q && pclk_en_q
    |=> !pclk_en_q) else $error("alternate pixel strobe too fast");
  a_alt_mem_full: assert property (mode_q[7:6] == 2'b11 && !mode_q[1] && ok_q
    |-> mclk_en_q) else $error("alternate memory strobe missing");
  a_def_equal_rate: assert property (mode_q[7:6] == 2'b10 && ok_q
    |-> pclk_en_q == mclk_en_q) else $error("default strobes differ");
  a_first_valid: assert property (pix_q.first |-> pix_q.valid)
    else $error("frame marker without pixel");
endmodule
bind rdr_refresh rdr_refresh_properties u_props (.clock(clock), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_q(pix_q),
  .pclk_en_q(pclk_en_q), .mclk_en_q(mclk_en_q));

// File: tb.sv
// Self-checking bench of the refresh path
`timescale 1ns/1ns
module tb;
  logic clock, rst_n, psel, penable, pwrite, fb_we, pready, pslverr, pclk_en_q, mclk_en_q;
  logic rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [16:0] fb_waddr;
  logic [7:0] fb_wdata;
  rdr_pkg::rdr_pix_t pix_q;
  int num_errors = 0;
  int n_tests = 0;
  logic [7:0] cf_rot [8] = '{8'h80, 8'h80, 8'hC0, 8'hC2, 8'h83, 8'h00, 8'h82, 8'hC1};
  logic [7:0] cf_str [8] = '{8'h04, 8'h04, 8'h03, 8'h03, 8'h00, 8'h04, 8'h04, 8'h04};
  logic [16:0] cf_st [8] = '{17'h5, 17'h6, 17'h5, 17'h8, 17'h205, 17'h5, 17'h5, 17'h5};
  logic [7:0] cf_ctl [8] = '{8'h32, 8'h33, 8'h32, 8'h32, 8'h32, 8'h02, 8'h26, 8'h12};
  rdr_refresh u_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fb_waddr(fb_waddr), .fb_wdata(fb_wdata), .fb_we(fb_we),
    .pix_q(pix_q), .pclk_en_q(pclk_en_q), .mclk_en_q(mclk_en_q));
  rdr_panel_model u_panel (.clock(clock), .pix_q(pix_q));
  // ==========
  // Clock and helpers
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task give_verdict;
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  function logic [23:0] colour_lookup_table(input logic [7:0] v);
    return {v, ~v, v + 8'h11};
  endfunction
  function logic [7:0] dat(input logic [16:0] a);
    return a[7:0] + {a[9:8], 6'h00};
  endfunction
  // Byte address of byte k of a two by two byte frame
  function logic [16:0] adr(input int c, input int k);
    logic [16:0] s;
    s = (cf_str[c] == 8'h00) ? 17'h100 : {9'h0, cf_str[c]};
    if (!cf_rot[c][7]) return 17'(cf_st[c] + k);
    return 17'(cf_st[c] - k / 2 + (k % 2) * s);
  endfunction
  task run(input int c);
    int bpp, ppb, n, k, to;
    logic [7:0] pv;
    logic [23:0] e;
    bpp = 1 << cf_ctl[c][5:4];
    ppb = 8 / bpp;
    n = 4 * ppb;
    for (k = 0; k < 4; k++) begin
      @(posedge clock);
      fb_we <= 1'b1; fb_waddr <= adr(c, k); fb_wdata <= dat(adr(c, k));
      @(posedge clock);
      fb_we <= 1'b0;
    end
    apb(1'b1, 12'h000, {24'h0, cf_rot[c]});
    apb(1'b1, 12'h004, {24'h0, cf_str[c]});
    apb(1'b1, 12'h008, {15'h0, cf_st[c]});
    apb(1'b1, 12'h010, 32'h00010001);
    u_panel.got.delete();
    apb(1'b1, 12'h00C, {24'h0, cf_ctl[c]});
    to = 0;
    while (u_panel.got.size() < n && to < 3000) begin
      @(posedge clock);
      to++;
    end
    if (to == 3000) num_errors++;
    apb(1'b1, 12'h00C, {24'h0, cf_ctl[c] & 8'hFD});
    for (k = 0; k < n; k++) begin
      pv = 8'((dat(adr(c, k / ppb)) >> (8 - bpp * (k % ppb + 1))) & ((1 << bpp) - 1));
      e = cf_ctl[c][0] ? ~colour_lookup_table(pv) : colour_lookup_table(pv);
      if (cf_ctl[c][2]) check({8'h0, u_panel.got[k]}, {8'h0, e[15:8], e[15:8], e[15:8]});
      else check({8'h0, u_panel.got[k]}, {8'h0, e});
    end
    to = 0;
    do begin
      apb(1'b0, 12'h014, 32'h0);
      to++;
    end while (rdata[31:28] !== 4'b0001 && to < 200);
    check({28'h0, rdata[31:28]}, 32'h1);
  endtask
  // ==========
  // Main sequence
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    fb_we = 1'b0; fb_waddr = 17'h0; fb_wdata = 8'h00; rst_n = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b1, 12'h000, 32'h000000C1);
    apb(1'b0, 12'h000, 32'h0);
    check(rdata, 32'h000000C1);
    apb(1'b0, 12'h018, 32'h0);
    check({31'h0, rerr}, 32'h1);
    for (int i = 0; i < 256; i++) apb(1'b1, 12'(12'h400 + i * 4), {8'h00, colour_lookup_table(8'(i))});
    apb(1'b0, 12'h404, 32'h0);
    check(rdata, 32'h0);
    for (int c = 0; c < 8; c++) run(c);
    give_verdict;
  end
  // Watchdog against a hang
  initial begin
    #400000;
    num_errors++;
    give_verdict;
  end
endmodule
